//--- rtl/apr_defs.vh
// Constants for the power and output-rate control of the acceleration core.
// Included by the core only; defines nothing but macros.
`ifndef APR_DEFS_VH
`define APR_DEFS_VH

// Register offsets
`define APR_RATE_SELECT_ADDR 8'h2C
`define APR_POWER_CONTROL_ADDR 8'h2D

// Field positions
`define APR_MEASURE_BIT 3
`define APR_LOW_POWER_BIT 4
`define APR_RATE_MSB 3
`define APR_RATE_LSB 0

// Reset values
`define APR_RATE_SELECT_RST 8'h0A
`define APR_POWER_CONTROL_RST 8'h00

// Timing: clock period, fastest output period and the code that gives it
`define APR_CLK_PERIOD_NS 10
`define APR_FAST_ODR_PERIOD_NS 312500
`define APR_FAST_ODR_CYCLES (`APR_FAST_ODR_PERIOD_NS / `APR_CLK_PERIOD_NS)
`define APR_FAST_RATE_CODE 4'hF

`endif

//--- rtl/apr_core.v
// Power state and output-data-rate control for a three-axis acceleration core.
// Assumes a serial decoder on the same clock presenting one-cycle register strobes.
// Offsets, field positions, reset values and the fastest period come from the shared header.
`timescale 1ns/1ps
`default_nettype none
`include "apr_defs.vh"

module apr_core #(
  parameter [31:0] FAST_ODR_CYCLES = `APR_FAST_ODR_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  output reg measuring,
  output reg sense_en,
  output reg low_power,
  output reg buffer_hold,
  output reg conv_tick,
  output reg odr_tick,
  output reg bw_tick
);

  // One-hot operating states
  localparam [1:0] ST_STANDBY = 2'b01;
  localparam [1:0] ST_MEASURE = 2'b10;

  // One-hot register selects from the offset decoder
  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_RATE = 2'h1;
  localparam [1:0] SEL_POWER = 2'h2;

  // Register contents
  reg [7:0] rate_select_r;
  reg [7:0] power_control_r;

  // Operating state, sample counter and bandwidth phase
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] cnt_r;
  reg [31:0] cnt_nxt;
  reg bw_phase_r;

  // Rate decode and counter matches
  wire [3:0] rate_code;
  wire [31:0] odr_period;
  wire [31:0] conv_period;
  wire conv_hit;
  wire odr_hit;
  wire in_measure;

  // Offset decode for the register port
  wire [1:0] wr_sel;
  wire [1:0] rd_sel;

  // Period of one output sample for a rate code
  // Slowest code shifts the default period by 15, which still fits in 32 bits
  function [31:0] odr_cycles;
    input [3:0] code;
    input [31:0] fast;
    begin
      odr_cycles = fast << (`APR_FAST_RATE_CODE - code);
    end
  endfunction

  // Offset decoder shared by the write and read paths, one bit per register
  function [1:0] reg_select;
    input [7:0] addr;
    begin
      reg_select = SEL_NONE;
      if (addr == `APR_RATE_SELECT_ADDR) begin
        reg_select = SEL_RATE;
      end
      if (addr == `APR_POWER_CONTROL_ADDR) begin
        reg_select = SEL_POWER;
      end
    end
  endfunction

  // Rate code decode; the period doubles for each step below the fastest code
  assign rate_code = rate_select_r[`APR_RATE_MSB:`APR_RATE_LSB];
  assign odr_period = odr_cycles(rate_code, FAST_ODR_CYCLES);
  // Normal mode converts twice per output sample, low power once
  assign conv_period = rate_select_r[`APR_LOW_POWER_BIT] ? odr_period
                       : {1'b0, odr_period[31:1]};
  assign conv_hit = (cnt_r == conv_period - 32'h0000_0001) ||
                    (cnt_r == odr_period - 32'h0000_0001);
  assign odr_hit = (cnt_r == odr_period - 32'h0000_0001);
  assign in_measure = (state_r == ST_MEASURE);
  // A write selects only while its strobe is up; a read in the same cycle sees the old value
  assign wr_sel = reg_wr ? reg_select(reg_addr) : SEL_NONE;
  assign rd_sel = reg_select(reg_addr);

  // Register writes are accepted in either state; no ordering is enforced, so
  // configuring while measuring is left to software and takes effect at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_select_r <= `APR_RATE_SELECT_RST;
      power_control_r <= `APR_POWER_CONTROL_RST;
    end else begin
      if (wr_sel == SEL_RATE) begin
        rate_select_r <= reg_wdata;
      end
      if (wr_sel == SEL_POWER) begin
        power_control_r <= reg_wdata;
      end
    end
  end

  // Read port; unmapped offsets read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      // Data holds between reads so a slow decoder may fetch it late
      if (reg_rd) begin
        case (rd_sel)
          SEL_RATE: reg_rdata <= rate_select_r;
          SEL_POWER: reg_rdata <= power_control_r;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Operating state follows the stored measure bit
  // One cycle from the stored bit to the state, a second to the level outputs
  always @* begin
    case (state_r)
      ST_STANDBY: state_nxt = power_control_r[`APR_MEASURE_BIT] ? ST_MEASURE
                              : ST_STANDBY;
      ST_MEASURE: state_nxt = power_control_r[`APR_MEASURE_BIT] ? ST_MEASURE
                              : ST_STANDBY;
      default: state_nxt = ST_STANDBY;
    endcase
  end

  // Sample counter restarts from zero on entering measurement; a rate change that
  // leaves it beyond the new period wraps it at once rather than counting on
  always @* begin
    cnt_nxt = 32'h0000_0000;
    if (in_measure && !odr_hit && cnt_r < odr_period) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
  end

  // Operating state and sample counter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_STANDBY;
      cnt_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Level outputs lag the state, and low_power the rate register, by one cycle so that each leaves a flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      measuring <= 1'h0;
      sense_en <= 1'h0;
      low_power <= 1'h0;
      buffer_hold <= 1'h1;
    end else begin
      measuring <= in_measure;
      sense_en <= in_measure;
      // Copy only; codes outside the useful low-power range are not blocked
      low_power <= rate_select_r[`APR_LOW_POWER_BIT];
      // Buffer is frozen, not cleared, so samples taken before standby survive
      buffer_hold <= !in_measure;
    end
  end

  // Conversion and output strobes, one cycle wide and silent in standby
  // The conversion match includes the output compare, so an output strobe always has a conversion beside it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_tick <= 1'h0;
      odr_tick <= 1'h0;
    end else begin
      conv_tick <= in_measure && conv_hit;
      odr_tick <= in_measure && odr_hit;
    end
  end

  // Bandwidth strobe on every second output strobe; the phase restarts with
  // each measurement so the first strobe always comes after two output periods
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bw_phase_r <= 1'h0;
      bw_tick <= 1'h0;
    end else if (!in_measure) begin
      bw_phase_r <= 1'h0;
      bw_tick <= 1'h0;
    end else begin
      if (odr_hit) begin
        bw_phase_r <= ~bw_phase_r;
      end
      bw_tick <= odr_hit && bw_phase_r;
    end
  end

endmodule
`default_nettype wire

//--- test/apr_core_sva.sv
// Checker for power state, read answers and rate ticks of the control core.
// Bound to every core instance; watches its ports only.
`timescale 1ns/1ps
`default_nettype none
module apr_core_chk (
  input wire clk,
  input wire rst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_rvalid,
  input wire measuring,
  input wire sense_en,
  input wire low_power,
  input wire buffer_hold,
  input wire conv_tick,
  input wire odr_tick,
  input wire bw_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Power control write, decoded once for both directions
  wire pw = reg_wr && reg_addr == 8'h2D;
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
  a_measure_on: assert property (pw && reg_wdata[3] |-> ##3 measuring) else $error("no entry");
  a_measure_off: assert property (pw && !reg_wdata[3] |-> ##3 !measuring) else $error("no exit");
  a_sense_same: assert property (sense_en == measuring) else $error("sense off");
  a_hold_out: assert property (buffer_hold == !measuring) else $error("hold wrong");
  // Standby must be silent, ticks too
  a_idle_quiet: assert property (!measuring |-> !odr_tick && !conv_tick && !bw_tick)
    else $error("tick in standby");
  a_bw_on_odr: assert property (bw_tick |-> odr_tick) else $error("stray bw tick");
  a_odr_conv: assert property (odr_tick |-> conv_tick) else $error("odr without conv");
  a_lp_single: assert property (low_power && conv_tick |-> odr_tick) else $error("extra conv");
  cover property ($rose(measuring));
  cover property (bw_tick);
  cover property (low_power && conv_tick);
endmodule
bind apr_core apr_core_chk chk_u (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rvalid, .measuring, .sense_en, .low_power, .buffer_hold, .conv_tick, .odr_tick, .bw_tick);
`default_nettype wire

//--- test/test_apr_core.sv
// Testbench for the power and rate control core, driven through its register strobes.
// Shortened fastest period of 4 cycles so every rate test stays brief.
`timescale 1ns/1ps
`default_nettype none
module test_apr_core;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire reg_rvalid, measuring, sense_en, low_power, buffer_hold, conv_tick, odr_tick, bw_tick;
  int fails = 0, comparisons = 0, n_odr, n_cnv, n_bw;
  always #5 clk = ~clk;
  apr_core #(.FAST_ODR_CYCLES(32'h0000_0004)) dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .measuring(measuring), .sense_en(sense_en), .low_power(low_power),
    .buffer_hold(buffer_hold), .conv_tick(conv_tick), .odr_tick(odr_tick), .bw_tick(bw_tick));
  // Tick counts drift by one with window alignment
  function automatic logic [7:0] near(input int a, input int b);
    return {7'h00, (a >= b - 1) && (a <= b + 1)};
  endfunction
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #1 reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk) #1 reg_rd = 0;
    chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
    chk("rdata", reg_rdata, e);
  endtask
  // Configure in standby, measure for 128 cycles, return to standby
  task run(input logic [7:0] rs, input int e);
    wr(8'h2C, rs);
    rd(8'h2C, rs);
    wr(8'h2D, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk("state", {5'h00, measuring, sense_en, buffer_hold}, 8'h06);
    chk("lp", {7'h00, low_power}, {7'h00, rs[4]});
    {n_odr, n_cnv, n_bw} = 0;
    repeat (128) begin
      @(posedge clk);
      #1 n_odr += odr_tick;
      n_cnv += conv_tick;
      n_bw += bw_tick;
    end
    chk("odr", near(n_odr, e), 8'h01);
    chk("conv", near(n_cnv, rs[4] ? e : 2 * e), 8'h01);
    chk("bw", near(n_bw, e / 2), 8'h01);
    wr(8'h2D, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("state", {5'h00, measuring, sense_en, buffer_hold}, 8'h01);
  endtask
  task tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    chk("state", {5'h00, measuring, sense_en, buffer_hold}, 8'h01);
    rd(8'h2C, 8'h0A);
    rd(8'h2D, 8'h00);
    rd(8'h30, 8'h00);
    run(8'h0F, 32);
    run(8'h0E, 16);
    run(8'h0D, 8);
    run(8'h1C, 4);
    tally_and_finish;
  end
endmodule
`default_nettype wire
